// ### design/internal_clock_unit.sv
// How it works
// - nine bit internal reference trim value
// - coarse trim binary weighted, larger is longer
// - fine trim bit held in status register
// - three bit reference divider select
// - output divider one, two, four, eight
// - debug clock is oscillator divided by two
// - reset enters FLL engaged internal mode
// - internal or external reference as system clock
// - reference up to 5 MHz drives FLL
// - status bit four reports reference source
// - source status changes only after synchronisation
// - mode status bits 3-2 after synchronisation
// - external oscillator control outputs provided
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module internal_clock_unit (
    input  wire logic        clock_i,          // 10 MHz system clock
    input  wire logic        rst_n_i,          // async reset, low
    input  wire logic [3:0]  address,          // avalon byte address
    input  wire logic        read,             // avalon read
    input  wire logic        write,            // avalon write
    input  wire logic [31:0] writedata,        // avalon write data
    input  wire logic [3:0]  byteenable,       // avalon byte enables
    output logic      [31:0] readdata,         // avalon read data
    output logic             waitrequest,      // avalon stall
    input  wire logic        dco_i,            // oscillator output pin
    input  wire logic        ext_ref_i,        // external reference pin
    input  wire logic        int_ref_i,        // internal reference pin
    input  wire logic        osc_ready_i,      // oscillator ready pin
    output logic [8:0]       ref_trim_o,       // nine bit period trim
    output logic [2:0]       ref_div_sel_o,    // reference divider
    output logic             fll_ref_o,        // divided FLL reference
    output logic             fll_engaged_o,    // FLL drives system
    output logic             sys_clk_o,        // selected, divided
    output logic             background_debug_clock_o, // dco / 2
    output logic             high_gain_osc_select_o,   // osc gain
    output logic             range_select_o,   // osc frequency range
    output logic             ext_ref_type_select_o,    // crystal/clock
    output logic             ext_ref_clock_enable_o,   // ext ref on
    output logic             ext_ref_stop_enable_o     // run in stop
);
    import clock_unit_pkg::*;

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  trim;
        logic        fine;
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic [31:0] rdata;
        logic        ack;
        logic [1:0]  dco_s;
        logic [1:0]  ext_s;
        logic [1:0]  int_s;
        logic [1:0]  osc_s;
        logic        dco_prev;
        logic        bdc;
        logic        ref_prev;
        logic        fllref;
        logic        src_prev;
        logic        sysclk;
        logic [2:0]  odiv_cnt;
        logic        osc_init;
        logic [8:0]  trim_o;
        logic [2:0]  rdiv_o;
        logic        fll_o;
        logic [5:0]  osc_o;
    } state_t;
    state_t q, d;

    clk_sel_if sel ();
    logic      ref_tick;
    logic      src_clk;
    logic      ref_clk;
    logic      odiv_tick;

    // decode a word offset against the bus address
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    //--------------------------------------------------------------
    // submodules
    //--------------------------------------------------------------
    // reported source and mode trail the request by two edges
    mode_sync u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .sel     (sel)
    );

    // reference divider, ticks once every 2**sel system clock cycles
    clk_divider u_rdiv (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .sel_i   (q.ctrl1[C1_RDIV_LO +: 3]),
        .tick_o  (ref_tick)
    );

    assign sel.mode_req = q.ctrl1[C1_MODE_LO +: 2];
    assign sel.ref_sel  = q.ctrl1[C1_REFSEL];

    // reference for the FLL: internal or external, per ref select
    assign ref_clk = sel.ref_stat ? q.int_s[1] : q.ext_s[1];

    // system source: FLL output or one reference directly
    always_comb begin
        unique case (mode_t'(sel.mode_stat))
            MODE_BINT: src_clk = q.int_s[1];
            MODE_BEXT: src_clk = q.ext_s[1];
            default:   src_clk = q.dco_s[1];
        endcase
    end

    // output divider: toggle sysclk every 2**odiv source transitions
    assign odiv_tick = (q.odiv_cnt ==
        3'((4'h1 << q.ctrl2[C2_ODIV_LO +: 2]) - 4'h1));

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb begin
        d = q;
        // pin synchronisers
        d.dco_s = {q.dco_s[0], dco_i};
        d.ext_s = {q.ext_s[0], ext_ref_i};
        d.int_s = {q.int_s[0], int_ref_i};
        d.osc_s = {q.osc_s[0], osc_ready_i};
        d.osc_init = q.osc_s[1] & q.ctrl2[C2_ERCLK];

        // debug clock toggles on each dco rising edge
        d.dco_prev = q.dco_s[1];
        if (q.dco_s[1] && !q.dco_prev) begin
            d.bdc = ~q.bdc;
        end

        // divided FLL reference
        d.ref_prev = ref_clk;
        if (ref_tick) begin
            d.fllref = ref_clk;
        end

        // output divider on every source transition; ratio 1 passes through
        d.src_prev = src_clk;
        if (q.ctrl2[C2_ODIV_LO +: 2] == 2'h0) begin
            d.sysclk   = src_clk;
            d.odiv_cnt = 3'h0;
        end else if (src_clk != q.src_prev) begin
            if (odiv_tick) begin
                d.sysclk   = ~q.sysclk;
                d.odiv_cnt = 3'h0;
            end else begin
                d.odiv_cnt = q.odiv_cnt + 3'h1;
            end
        end

        // bus slave: one wait cycle, then acknowledge
        // a write lands only on the edge where the stall is seen low
        d.ack = (read | write) & ~q.ack;
        if (write && q.ack && byteenable[0]) begin
            if (hit(address, OFF_TRIM)) begin
                d.trim = writedata[7:0];
            end
            if (hit(address, OFF_STATUS)) begin
                d.fine = writedata[ST_FINE_PERIOD_TRIM];
            end
            if (hit(address, OFF_CTRL1)) begin
                d.ctrl1 = writedata[7:0];
            end
            if (hit(address, OFF_CTRL2)) begin
                d.ctrl2 = writedata[7:0];
            end
        end
        d.rdata = 32'h0000_0000;
        if (read && !q.ack) begin
            if (hit(address, OFF_TRIM)) begin
                d.rdata[7:0] = q.trim;
            end
            if (hit(address, OFF_STATUS)) begin
                d.rdata[ST_REFST] = sel.ref_stat;
                d.rdata[ST_MODE_LO +: 2] = sel.mode_stat;
                d.rdata[ST_OSC_INIT_STATUS] = q.osc_init;
                d.rdata[ST_FINE_PERIOD_TRIM] = q.fine;
            end
            if (hit(address, OFF_CTRL1)) begin
                d.rdata[7:0] = q.ctrl1;
            end
            if (hit(address, OFF_CTRL2)) begin
                d.rdata[7:0] = q.ctrl2;
            end
        end

        // registered outputs
        d.trim_o = {q.trim, q.fine};
        d.rdiv_o = q.ctrl1[C1_RDIV_LO +: 3];
        d.fll_o  = (mode_t'(sel.mode_stat) == MODE_FLL);
        d.osc_o  = {q.ctrl2[C2_HGO], q.ctrl2[C2_RANGE],
                    q.ctrl2[C2_TYPE], q.ctrl2[C2_ERCLK],
                    q.ctrl2[C2_STOPEN], 1'b0};
    end

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------
    // reset lands in FLL engaged internal: mode 0, internal ref
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q       <= '0;
            q.trim  <= TRIM_RST;
            q.ctrl1 <= CTRL1_RST;
            q.ctrl2 <= CTRL2_RST;
            q.trim_o <= {TRIM_RST, 1'b0};
            q.fll_o <= 1'b1;
        end else begin
            q <= d;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign readdata                 = q.rdata;
    assign waitrequest              = ~q.ack;
    assign ref_trim_o               = q.trim_o;
    assign ref_div_sel_o            = q.rdiv_o;
    assign fll_ref_o                = q.fllref;
    assign fll_engaged_o            = q.fll_o;
    assign sys_clk_o                = q.sysclk;
    assign background_debug_clock_o = q.bdc;
    assign high_gain_osc_select_o   = q.osc_o[5];
    assign range_select_o           = q.osc_o[4];
    assign ext_ref_type_select_o    = q.osc_o[3];
    assign ext_ref_clock_enable_o   = q.osc_o[2];
    assign ext_ref_stop_enable_o    = q.osc_o[1];
endmodule

// ### inc/clock_unit_pkg.sv
package clock_unit_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0] OFF_TRIM    = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_CTRL1   = 4'h8;
    localparam logic [3:0] OFF_CTRL2   = 4'hC;
    // reset values
    localparam logic [7:0] TRIM_RST    = 8'h80;
    localparam logic [7:0] CTRL1_RST   = 8'h04;
    localparam logic [7:0] CTRL2_RST   = 8'h00;
    // status register fields
    localparam int         ST_REFST    = 4;
    localparam int         ST_MODE_LO  = 2;
    localparam int         ST_OSC_INIT_STATUS  = 1;
    localparam int         ST_FINE_PERIOD_TRIM    = 0;
    // control 1 fields: mode request [7:6], ref div [5:3], ref sel [2]
    localparam int         C1_MODE_LO  = 6;
    localparam int         C1_RDIV_LO  = 3;
    localparam int         C1_REFSEL   = 2;
    // control 2 fields: out div [7:6], range, hgo, type, clk en, stop en
    localparam int         C2_ODIV_LO  = 6;
    localparam int         C2_RANGE    = 5;
    localparam int         C2_HGO      = 4;
    localparam int         C2_TYPE     = 3;
    localparam int         C2_ERCLK    = 2;
    localparam int         C2_STOPEN   = 1;
    // osc start count and maximum reference frequency
    localparam logic [7:0] OSC_START   = 8'hFF;
    localparam logic [31:0] MAX_REF_HZ = 32'd5000000;
    typedef enum logic [1:0] {
        MODE_FLL  = 2'b00,
        MODE_BINT = 2'b01,
        MODE_BEXT = 2'b10,
        MODE_RSVD = 2'b11
    } mode_t;
endpackage

// ### inc/clk_sel_if.sv
`timescale 1ns/1ps
interface clk_sel_if;
    logic [1:0] mode_req;
    logic       ref_sel;
    logic [1:0] mode_stat;
    logic       ref_stat;
    modport ctrl (output mode_req, output ref_sel,
                  input mode_stat, input ref_stat);
    modport sync (input mode_req, input ref_sel,
                  output mode_stat, output ref_stat);
endinterface

// ### design/mode_sync.sv
`timescale 1ns/1ps
module mode_sync (
    input  wire logic clock_i,  // system clock
    input  wire logic rst_n_i,  // async reset, low
    clk_sel_if.sync   sel       // request in, status out
);
    import clock_unit_pkg::*;
    typedef struct packed {
        logic [1:0] m1;
        logic [1:0] m2;
        logic       r1;
        logic       r2;
    } sync_t;
    sync_t q, d;
    // two stages between request and reported status
    always_comb begin
        d    = q;
        d.m1 = sel.mode_req;
        d.m2 = q.m1;
        d.r1 = sel.ref_sel;
        d.r2 = q.r1;
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{m1: 2'h0, m2: 2'h0, r1: 1'b1, r2: 1'b1};
        end else begin
            q <= d;
        end
    end
    assign sel.mode_stat = q.m2;
    assign sel.ref_stat  = q.r2;
endmodule

// ### design/clk_divider.sv
`timescale 1ns/1ps
module clk_divider (
    input  wire logic       clock_i,  // system clock
    input  wire logic       rst_n_i,  // async reset, low
    input  wire logic [2:0] sel_i,    // divide by 2**sel
    output logic            tick_o    // one pulse per divided period
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } div_t;
    div_t q, d;
    logic [7:0] lim;
    // count to 2**sel - 1 then pulse
    always_comb begin
        lim    = 8'((9'h001 << sel_i) - 9'h001);
        d      = q;
        d.tick = (q.cnt >= lim);
        d.cnt  = d.tick ? 8'h00 : q.cnt + 8'h01;
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign tick_o = q.tick;
endmodule

// ### tb/unit_chk_assertions.sv
`timescale 1ns/1ps
module unit_chk
    import clock_unit_pkg::*;
(
    input wire logic        clock_i,     // system clock
    input wire logic        rst_n_i,     // async reset, low
    input wire logic [3:0]  address,     // bus address
    input wire logic        read,        // bus read
    input wire logic        write,       // bus write
    input wire logic [31:0] writedata,   // bus write data
    input wire logic [3:0]  byteenable,  // byte enables
    input wire logic [31:0] readdata,    // bus read data
    input wire logic        waitrequest, // bus stall
    input wire logic        dco_i,       // oscillator pin
    input wire logic [8:0]  ref_trim_o,  // period trim
    input wire logic [2:0]  ref_div_sel_o,            // ref divide
    input wire logic        fll_engaged_o,            // fll drives
    input wire logic        background_debug_clock_o, // dco / 2
    input wire logic        high_gain_osc_select_o    // osc gain
);
    // ----------------------------------------------------------------
    // bus and register output properties
    // ----------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic wr_ack;
    // a write accepted on this edge
    assign wr_ack = write && !waitrequest && byteenable[0];
    a_idle_wait: assert property (!(read || write) |-> waitrequest)
        else $error("stall dropped without request");
    a_ack_next: assert property ((read || write) && waitrequest |=>
        !waitrequest) else $error("request not answered next cycle");
    a_ack_single: assert property (!waitrequest |=> waitrequest)
        else $error("acknowledge longer than one cycle");
    a_upper_zero: assert property (read && !waitrequest |->
        readdata[31:8] == 24'h000000) else $error("upper read bits set");
    a_unmapped_read: assert property (read && !waitrequest &&
        address[1:0] != 2'h0 |-> readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_trim_out: assert property (wr_ack && address == OFF_TRIM |->
        ##2 ref_trim_o[8:1] == $past(writedata[7:0], 2))
        else $error("trim output not following write");
    a_rdiv_out: assert property (wr_ack && address == OFF_CTRL1 |->
        ##2 ref_div_sel_o == $past(writedata[5:3], 2))
        else $error("divide select not following write");
    a_gain_out: assert property (wr_ack && address == OFF_CTRL2 |->
        ##2 high_gain_osc_select_o == $past(writedata[4], 2))
        else $error("gain select not following write");
    a_mode_hold: assert property (wr_ack && address == OFF_CTRL1 |=>
        $stable(fll_engaged_o)) else $error("mode changed without sync");
    a_mode_set: assert property (wr_ack && address == OFF_CTRL1 |->
        ##5 fll_engaged_o == ($past(writedata[7:6], 5) == 2'h0))
        else $error("engaged flag wrong after mode write");
    a_debug_clk: assert property ($rose(dco_i) |->
        ##[1:6] $changed(background_debug_clock_o))
        else $error("debug clock not toggling");
    // main scenarios reached
    c_mode_write: cover property (wr_ack && address == OFF_CTRL1);
    c_status_read: cover property (read && !waitrequest && address == 4'h4);
    c_debug_rise: cover property ($rose(background_debug_clock_o));
endmodule
bind internal_clock_unit unit_chk unit_chk_i (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .dco_i(dco_i), .ref_trim_o(ref_trim_o),
    .ref_div_sel_o(ref_div_sel_o), .fll_engaged_o(fll_engaged_o),
    .background_debug_clock_o(background_debug_clock_o),
    .high_gain_osc_select_o(high_gain_osc_select_o));

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("mismatch %s exp %0h got %0h", n, e, g); \
    end \
end
module tb_top;
    import clock_unit_pkg::*;
    logic clock_i, rst_n_i, read, write, dco_i, ext_ref_i, int_ref_i;
    logic osc_ready_i, waitrequest, fll_ref_o, fll_engaged_o, sys_clk_o;
    logic bdc, high_gain_osc_select, rng, typ, clken, stopen;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata;
    logic [8:0] ref_trim_o;
    logic [2:0] ref_div_sel_o;
    logic [7:0] q, trim, c1, c2, pin_cnt;
    logic fine;
    int seed, error_cnt, checks_done, sys_cnt, src_cnt, bdc_cnt, dco_cnt;
    int s0, r0, b0, o0, ref_cnt, f0;
    internal_clock_unit internal_clock_unit_i (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .dco_i(dco_i), .ext_ref_i(ext_ref_i),
        .int_ref_i(int_ref_i), .osc_ready_i(osc_ready_i),
        .ref_trim_o(ref_trim_o), .ref_div_sel_o(ref_div_sel_o),
        .fll_ref_o(fll_ref_o), .fll_engaged_o(fll_engaged_o),
        .sys_clk_o(sys_clk_o), .background_debug_clock_o(bdc),
        .high_gain_osc_select_o(high_gain_osc_select), .range_select_o(rng),
        .ext_ref_type_select_o(typ), .ext_ref_clock_enable_o(clken),
        .ext_ref_stop_enable_o(stopen));
    // ----------------------------------------------------------------
    // clock, pin sources and edge counters
    // ----------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = !clock_i;
    end
    // oscillator and reference pins at unrelated rates
    always @(posedge clock_i) begin
        pin_cnt <= pin_cnt + 8'h01;
        if (pin_cnt % 3 == 0) dco_i <= !dco_i;
        if (pin_cnt[1:0] == 2'h3) int_ref_i <= !int_ref_i;
        if (pin_cnt % 5 == 0) ext_ref_i <= !ext_ref_i;
    end
    always @(posedge sys_clk_o) sys_cnt++;
    always @(posedge int_ref_i) src_cnt++;
    always @(posedge bdc) bdc_cnt++;
    always @(posedge dco_i) dco_cnt++;
    always @(posedge fll_ref_o) ref_cnt++;
    // expected status byte from the programmed controls
    function automatic logic [7:0] exp_status(input logic [7:0] m,
        input logic [7:0] o, input logic rdy, input logic f);
        return {3'h0, m[2], m[7:6], rdy & o[2], f};
    endfunction
    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction
    // one bus transfer, held until the stall is seen low
    task automatic bus_op(input logic rd, input logic [3:0] a,
        input logic [7:0] d, input logic [3:0] be, output logic [7:0] v);
        int n;
        n = 0;
        address <= a;
        read <= rd;
        write <= !rd;
        writedata <= {24'h000000, d};
        byteenable <= be;
        do begin
            @(posedge clock_i);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40) error_cnt++;
        v = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        bus_op(1'b1, a, 8'h00, 4'hF, v);
        `CHK("readdata", e, v)
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
    // main sequence
    initial begin
        {rst_n_i, read, write, dco_i, ext_ref_i, int_ref_i} = 6'h00;
        {osc_ready_i, address, writedata, byteenable} = '0;
        pin_cnt = 8'h00;
        seed = 93;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        `CHK("trim_out", 9'h100, ref_trim_o)
        `CHK("engaged", 1'b1, fll_engaged_o)
        rd_chk(OFF_TRIM, TRIM_RST);
        rd_chk(OFF_STATUS, 8'h10);
        rd_chk(OFF_CTRL1, CTRL1_RST);
        rd_chk(OFF_CTRL2, CTRL2_RST);
        bus_op(1'b0, 4'h1, 8'hFF, 4'hF, q);
        bus_op(1'b0, OFF_TRIM, 8'h3C, 4'hE, q);
        rd_chk(OFF_TRIM, TRIM_RST);
        rd_chk(4'h2, 8'h00);
        for (int i = 0; i < 30; i++) begin
            trim = 8'($random(seed));
            fine = 1'($random(seed));
            c2 = 8'($random(seed));
            c1 = {2'(i % 3), 3'($random(seed)), 1'($random(seed)), 2'h0};
            osc_ready_i <= 1'($random(seed));
            bus_op(1'b0, OFF_TRIM, trim, 4'hF, q);
            bus_op(1'b0, OFF_STATUS, {7'($random(seed)), fine}, 4'hF, q);
            bus_op(1'b0, OFF_CTRL2, c2, 4'hF, q);
            bus_op(1'b0, OFF_CTRL1, c1, 4'hF, q);
            repeat (6) @(posedge clock_i);
            `CHK("trim_out", {trim, fine}, ref_trim_o)
            `CHK("div_sel", c1[5:3], ref_div_sel_o)
            `CHK("engaged", c1[7:6] == 2'h0, fll_engaged_o)
            `CHK("osc_ctl", {c2[5:1]}, {rng, high_gain_osc_select, typ, clken, stopen})
            rd_chk(OFF_STATUS, exp_status(c1, c2, osc_ready_i, fine));
            rd_chk(OFF_TRIM, trim);
        end
        // bypass on internal reference, sweep the output divider
        bus_op(1'b0, OFF_CTRL1, 8'h44, 4'hF, q);
        for (int d = 0; d < 4; d++) begin
            bus_op(1'b0, OFF_CTRL2, 8'(d << 6), 4'hF, q);
            repeat (8) @(posedge clock_i);
            {s0, r0, b0, o0} = {sys_cnt, src_cnt, bdc_cnt, dco_cnt};
            f0 = ref_cnt;
            repeat (512) @(posedge clock_i);
            `CHK("sys_div", 1'b1, near(sys_cnt - s0, (src_cnt - r0) >> d))
            `CHK("bdc_div", 1'b1, near(2 * (bdc_cnt - b0), dco_cnt - o0))
            `CHK("fll_ref", 1'b1, near(ref_cnt - f0, src_cnt - r0))
        end
        print_verdict();
    end
endmodule
